// ===== hdl/vmc_ctrl.v
/*
 * digital control side of a three-channel supply voltage monitor with an
 * ahb-lite register slave, monitor reset, interrupt requests and event pulses.
 * assumes: comparator results and the low-speed oscillator arrive
 * asynchronously; a single ahb-lite master; one clock, synchronous reset.
 */
//
// Function
// - channels 1 and 2 show a live flag telling whether the input is above the threshold.
// - channels 1 and 2 set a crossing flag on every rise or fall past the threshold.
// - channel 0 holds reset while low and releases a fixed delay after it recovers.
// - channels 1 and 2 assert reset on a drop, released a fixed delay after recovery or drop.
// - channel interrupts are non-maskable in the basic variant, selectable when extended.
// - a per-channel condition raises the interrupt on fall, rise or both.
// - condition code 00 is rise, 01 is fall, 10 is both and 11 raises nothing.
// - the basic variant filters channels 1 and 2 at one oscillator period times n (1,2,4,8).
// - the extended variant emits an event pulse on each crossing of channels 1 and 2.
// - the extended variant lets channel 2 watch the external pin instead of the supply.
// - the channel 2 level flag reads 1 at or above threshold or when disabled, else 0.
`timescale 1ns/1ps
`include "vmc_defs.vh"

module vmc_ctrl #(
  parameter EXTENDED = 1,
  parameter REL_CYC = `VMC_REL_CYC,
  parameter CNT_W = 16
) (
  // clock and reset
  input wire core_clk_in,
  input wire srst_in,
  // comparator results, high when input at or above threshold, then the low-speed oscillator
  input wire thresh_ch0_in,
  input wire thresh_ch1_in,
  input wire thresh_ch2_in,
  input wire ext_compare_pin_in,
  input wire low_speed_osc_in,
  // ahb-lite slave
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg hreadyout_out,
  output reg hresp_out,
  output reg [31:0] hrdata_out,
  // system side
  output reg cpu_reset_out,
  output reg nmi_out,
  output reg irq_out,
  output reg [1:0] event_out
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  reg [4:0] raw_s1_reg;
  reg [4:0] raw_s2_reg;
  reg osc_d_reg;
  wire osc_tick;

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      raw_s1_reg <= 5'h00;
      raw_s2_reg <= 5'h00;
      osc_d_reg <= 1'b0;
    end else begin
      raw_s1_reg <= {low_speed_osc_in, ext_compare_pin_in, thresh_ch2_in,
                     thresh_ch1_in, thresh_ch0_in};
      raw_s2_reg <= raw_s1_reg;
      osc_d_reg <= raw_s2_reg[4];
    end
  end

  assign osc_tick = raw_s2_reg[4] & ~osc_d_reg;

  // ************************************************************
  // registers and bus data phase
  // ************************************************************
  reg [`VMC_CFG_W-1:0] cfg_reg [1:2];
  reg [1:0] cross_reg;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  wire [1:0] cross_clr;
  wire addr_phase;

  assign addr_phase = hsel_in & htrans_in[1] & hready_in;
  assign cross_clr = (wr_pend_reg && wr_addr_reg == `VMC_OFS_STATUS) ?
                     hwdata_in[`VMC_ST_CROSS2:`VMC_ST_CROSS1] : 2'h0;

  // ************************************************************
  // per-channel level path, flags and events
  // ************************************************************
  reg lvl0_reg;
  reg [2:0] lvl_d_reg;
  wire [2:0] lvl;
  wire [2:0] en;
  wire [2:0] rise;
  wire [2:0] fall;
  wire [2:0] rst_arm;
  wire [2:0] irq_hit;
  wire [2:0] type_nmi;
  wire [2:0] rst_act;

  assign lvl[0] = lvl0_reg;
  assign en[0] = 1'b1;
  assign rise[0] = lvl[0] & ~lvl_d_reg[0];
  assign fall[0] = ~lvl[0] & lvl_d_reg[0];
  assign rst_arm[0] = ~lvl[0];
  assign irq_hit[0] = 1'b0;
  assign type_nmi[0] = 1'b0;

  genvar c;
  generate
    for (c = 1; c <= 2; c = c + 1) begin : g_chan
      reg [2:0] div_cnt_reg;
      reg smp_reg;
      reg lvl_c_reg;
      wire [2:0] div_last;
      wire [1:0] cond;
      wire src;
      wire filt_on;

      assign cond = cfg_reg[c][`VMC_CFG_COND_HI:`VMC_CFG_COND_LO];
      assign div_last = (3'h1 << cfg_reg[c][`VMC_CFG_DIV_HI:`VMC_CFG_DIV_LO]) - 3'h1;
      assign filt_on = (EXTENDED == 0) && cfg_reg[c][`VMC_CFG_FILTEN];
      if (c == 2) begin : g_sel
        assign src = (EXTENDED != 0 && cfg_reg[c][`VMC_CFG_INSEL]) ?
                     raw_s2_reg[3] : raw_s2_reg[2];
      end else begin : g_nosel
        assign src = raw_s2_reg[1];
      end

      assign lvl[c] = lvl_c_reg;
      assign en[c] = cfg_reg[c][`VMC_CFG_EN];
      assign rise[c] = en[c] & lvl[c] & ~lvl_d_reg[c];
      assign fall[c] = en[c] & ~lvl[c] & lvl_d_reg[c];
      // drop-timed release arms only on the fall itself
      assign rst_arm[c] = en[c] & cfg_reg[c][`VMC_CFG_RSTEN] &
                          (cfg_reg[c][`VMC_CFG_RELSEL] ? fall[c] : ~lvl[c]);
      assign irq_hit[c] = cfg_reg[c][`VMC_CFG_IRQEN] &
                          (((cond == `VMC_COND_RISE) & rise[c]) |
                           ((cond == `VMC_COND_FALL) & fall[c]) |
                           ((cond == `VMC_COND_BOTH) & (rise[c] | fall[c])));
      assign type_nmi[c] = (EXTENDED == 0) | ~cfg_reg[c][`VMC_CFG_IRQTYPE];

      // with the filter on, level moves only when two successive samples agree; otherwise it follows the input
      always @(posedge core_clk_in) begin
        if (srst_in) begin
          div_cnt_reg <= 3'h0;
          smp_reg <= 1'b1;
          lvl_c_reg <= 1'b1;
        end else if (filt_on) begin
          if (osc_tick) begin
            if (div_cnt_reg >= div_last) begin
              div_cnt_reg <= 3'h0;
              smp_reg <= src;
              if (smp_reg == src) begin
                lvl_c_reg <= src;
              end
            end else begin
              div_cnt_reg <= div_cnt_reg + 3'h1;
            end
          end
        end else begin
          div_cnt_reg <= 3'h0;
          smp_reg <= src;
          lvl_c_reg <= src;
        end
      end
    end
  endgenerate

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      lvl0_reg <= 1'b0;
      lvl_d_reg <= 3'h7;
    end else begin
      lvl0_reg <= raw_s2_reg[0];
      lvl_d_reg <= lvl;
    end
  end

  // ************************************************************
  // reset release timers, one per channel
  // ************************************************************
  generate
    for (c = 0; c <= 2; c = c + 1) begin : g_rel
      reg [CNT_W-1:0] cnt_reg;
      reg act_reg;
      assign rst_act[c] = act_reg;
      // channel 0 starts in reset so the core waits for a good supply
      always @(posedge core_clk_in) begin
        if (srst_in) begin
          act_reg <= (c == 0) ? 1'b1 : 1'b0;
          cnt_reg <= {CNT_W{1'b0}};
        end else if (!en[c]) begin
          act_reg <= 1'b0;
          cnt_reg <= {CNT_W{1'b0}};
        end else if (rst_arm[c]) begin
          act_reg <= 1'b1;
          cnt_reg <= {CNT_W{1'b0}};
        end else if (act_reg) begin
          if (cnt_reg == REL_CYC[CNT_W-1:0] - 1'b1) begin
            act_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // outputs, flags and register access
  // ************************************************************
  wire [31:0] status_word;

  // level flags read 1 while disabled; channel 0 has no level flag
  assign status_word = {26'h0, 1'b0, cpu_reset_out, cross_reg,
                        lvl[2] | ~en[2], lvl[1] | ~en[1]};

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      cfg_reg[1] <= `VMC_CFG_RST;
      cfg_reg[2] <= `VMC_CFG_RST;
      cross_reg <= 2'h0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      hrdata_out <= 32'h0;
      cpu_reset_out <= 1'b1;
      nmi_out <= 1'b0;
      irq_out <= 1'b0;
      event_out <= 2'h0;
    end else begin
      // set wins over a clear in the same cycle
      cross_reg <= (cross_reg & ~cross_clr) | (rise[2:1] | fall[2:1]);
      cpu_reset_out <= |rst_act;
      nmi_out <= |(irq_hit & type_nmi);
      irq_out <= |(irq_hit & ~type_nmi);
      event_out <= (EXTENDED != 0) ? (rise[2:1] | fall[2:1]) : 2'h0;
      wr_pend_reg <= addr_phase & hwrite_in;
      wr_addr_reg <= haddr_in[7:0];
      if (wr_pend_reg) begin
        if (wr_addr_reg == `VMC_OFS_CH1_CFG) begin
          cfg_reg[1] <= hwdata_in[`VMC_CFG_W-1:0];
        end else if (wr_addr_reg == `VMC_OFS_CH2_CFG) begin
          cfg_reg[2] <= hwdata_in[`VMC_CFG_W-1:0];
        end
      end
      // read data is captured at the address phase; unmapped reads zero
      if (addr_phase && !hwrite_in) begin
        if (haddr_in[7:0] == `VMC_OFS_CH1_CFG) begin
          hrdata_out <= {21'h0, cfg_reg[1]};
        end else if (haddr_in[7:0] == `VMC_OFS_CH2_CFG) begin
          hrdata_out <= {21'h0, cfg_reg[2]};
        end else if (haddr_in[7:0] == `VMC_OFS_STATUS) begin
          hrdata_out <= status_word;
        end else begin
          hrdata_out <= 32'h0;
        end
      end
    end
  end

endmodule

// ===== hdl/vmc_defs.vh
/*
 * constants of the voltage monitor control block: register offsets,
 * field positions, reset values and release timing.
 * assumes: included by the block's design file by its bare name.
 */
`ifndef VMC_DEFS_VH
`define VMC_DEFS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define VMC_OFS_CH1_CFG 8'h04
`define VMC_OFS_CH2_CFG 8'h08
`define VMC_OFS_STATUS 8'h0C

// ************************************************************
// channel configuration fields
// ************************************************************
`define VMC_CFG_W 11
`define VMC_CFG_RST 11'h000
`define VMC_CFG_EN 0
`define VMC_CFG_RSTEN 1
`define VMC_CFG_IRQEN 2
`define VMC_CFG_RELSEL 3
`define VMC_CFG_IRQTYPE 4
`define VMC_CFG_COND_LO 5
`define VMC_CFG_COND_HI 6
`define VMC_CFG_FILTEN 7
`define VMC_CFG_DIV_LO 8
`define VMC_CFG_DIV_HI 9
`define VMC_CFG_INSEL 10

// ************************************************************
// interrupt condition codes
// ************************************************************
`define VMC_COND_RISE 2'h0
`define VMC_COND_FALL 2'h1
`define VMC_COND_BOTH 2'h2

// ************************************************************
// status fields
// ************************************************************
`define VMC_ST_LVL1 0
`define VMC_ST_LVL2 1
`define VMC_ST_CROSS1 2
`define VMC_ST_CROSS2 3
`define VMC_ST_CPURST 4
`define VMC_ST_LVL0 5

// ************************************************************
// release delay
// ************************************************************
`define VMC_REL_DELAY_NS 10000
`define VMC_CLK_PERIOD_NS 10
`define VMC_REL_CYC (`VMC_REL_DELAY_NS / `VMC_CLK_PERIOD_NS)

`endif

// ===== sim/vmc_cmp_model.sv
/* comparator and system-side model for the voltage monitor.
   assumes: bench moves levels through set_lvl; one core clock. */
`timescale 1ns/1ps
module vmc_cmp_model (
  // clock and requests
  input wire core_clk_in,
  input wire nmi_in,
  input wire irq_in,
  input wire [1:0] event_in,
  // comparator side
  output logic [2:0] thresh_out,
  output logic ext_pin_out,
  output logic osc_out
);
  int nmi_cnt = 0;
  int irq_cnt = 0;
  int ev_cnt = 0;
  int ev2_cnt = 0;
  initial begin
    thresh_out = 3'h7;
    ext_pin_out = 1'b1;
    osc_out = 1'b0;
  end
  // runs free, unrelated in phase to the core clock
  always #37 osc_out = ~osc_out;
  always @(posedge core_clk_in) begin
    nmi_cnt <= nmi_cnt + nmi_in;
    irq_cnt <= irq_cnt + irq_in;
    ev_cnt <= ev_cnt + event_in[0];
    ev2_cnt <= ev2_cnt + event_in[1];
  end
  task automatic set_lvl(input int ch, input logic v);
    @(posedge core_clk_in);
    if (ch == 3) ext_pin_out <= v;
    else thresh_out[ch] <= v;
  endtask
endmodule

// ===== sim/vmc_ctrl_properties.sv
/* port checker for the voltage monitor control block.
   assumes: bound into vmc_ctrl; one clock, synchronous reset. */
`timescale 1ns/1ps
module vmc_ctrl_properties #(
  parameter REL_CYC = 1000
) (
  input wire core_clk_in,
  input wire srst_in,
  input wire thresh_ch0_in,
  input wire thresh_ch1_in,
  input wire thresh_ch2_in,
  input wire ext_compare_pin_in,
  input wire hreadyout_out,
  input wire hresp_out,
  input wire cpu_reset_out,
  input wire nmi_out,
  input wire irq_out,
  input wire [1:0] event_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic [15:0] hi_cnt;
  logic [7:0] h1, h2, hx;
  // a crossing shows about 4 edges on; the window forgives one edge either way
  wire m1 = h1[2] ^ h1[5];
  wire m2 = (h2[2] ^ h2[5]) | (hx[2] ^ hx[5]);
  always @(posedge core_clk_in) begin
    h1 <= {h1[6:0], thresh_ch1_in};
    h2 <= {h2[6:0], thresh_ch2_in};
    hx <= {hx[6:0], ext_compare_pin_in};
    if (srst_in || !thresh_ch0_in) hi_cnt <= 16'h0000;
    else if (hi_cnt != 16'hFFFF) hi_cnt <= hi_cnt + 16'h0001;
  end
  bus_okay_a: assert property (hreadyout_out && !hresp_out)
    else $error("bus stalled or error");
  ch0_hold_a: assert property ((!thresh_ch0_in) [*5] |=> cpu_reset_out)
    else $error("reset off while low");
  ch0_release_a: assert property ($fell(cpu_reset_out) |-> hi_cnt >= REL_CYC)
    else $error("reset released early");
  nmi_cause_a: assert property (nmi_out |-> m1 || m2)
    else $error("nmi without crossing");
  irq_cause_a: assert property (irq_out |-> m1 || m2)
    else $error("irq without crossing");
  ev1_cause_a: assert property (event_out[0] |-> m1)
    else $error("event 1 without crossing");
  ev2_cause_a: assert property (event_out[1] |-> m2)
    else $error("event 2 without crossing");
  nmi_pulse_a: assert property (nmi_out |=> !nmi_out)
    else $error("nmi longer than a cycle");
endmodule
bind vmc_ctrl vmc_ctrl_properties #(.REL_CYC(REL_CYC)) u_props (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .thresh_ch0_in(thresh_ch0_in),
  .thresh_ch1_in(thresh_ch1_in), .thresh_ch2_in(thresh_ch2_in),
  .ext_compare_pin_in(ext_compare_pin_in), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .cpu_reset_out(cpu_reset_out), .nmi_out(nmi_out),
  .irq_out(irq_out), .event_out(event_out));

// ===== sim/voltage_monitor_ctrl_tb.sv
/* self-checking bench for the voltage monitor control block.
   assumes: defs header on the include path; comparator model alongside. */
`timescale 1ns/1ps
`include "vmc_defs.vh"
module voltage_monitor_ctrl_tb;
  localparam int REL = 8;
  localparam logic [31:0] EN = 32'h1, RS = 32'h2, IQ = 32'h4, SL = 32'h8, TY = 32'h10;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, rst, nmi, irq, ext, osc;
  logic [31:0] hrdata, q;
  logic [1:0] ev;
  logic [2:0] thr;
  logic [31:0] hrdata_b, qb;
  logic nmi_b;
  int nmi_b_cnt = 0;
  int failures = 0;
  int samples_checked = 0;
  always #5 core_clk_in = ~core_clk_in;
  vmc_cmp_model cmp (.core_clk_in(core_clk_in), .nmi_in(nmi), .irq_in(irq), .event_in(ev),
    .thresh_out(thr), .ext_pin_out(ext), .osc_out(osc));
  vmc_ctrl #(.REL_CYC(REL)) dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .thresh_ch0_in(thr[0]),
    .thresh_ch1_in(thr[1]), .thresh_ch2_in(thr[2]), .ext_compare_pin_in(ext),
    .low_speed_osc_in(osc), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .cpu_reset_out(rst), .nmi_out(nmi), .irq_out(irq), .event_out(ev));
  // basic variant on the same bus; it answers with zero wait states as well
  vmc_ctrl #(.EXTENDED(0), .REL_CYC(REL)) dut_basic (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .thresh_ch0_in(thr[0]),
    .thresh_ch1_in(thr[1]), .thresh_ch2_in(thr[2]), .ext_compare_pin_in(ext),
    .low_speed_osc_in(osc), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(), .hresp_out(), .hrdata_out(hrdata_b),
    .cpu_reset_out(), .nmi_out(nmi_b), .irq_out(), .event_out());
  always @(posedge core_clk_in) nmi_b_cnt <= nmi_b_cnt + nmi_b;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic check(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %b", $time, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge core_clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk_in); while (hready !== 1'b1);
    q = hrdata;
    qb = hrdata_b;
  endtask
  task automatic st(input int b, input logic e);
    bus(1'b0, 8'h0C, 32'h0);
    check(q[b], e);
  endtask
  task automatic lvl(input int ch, input logic v);
    cmp.set_lvl(ch, v);
    tick(10);
  endtask
  task automatic t_ch0();
    lvl(0, 1'b0);
    check(rst, 1'b1);
    st(`VMC_ST_LVL0, 1'b0);
    cmp.set_lvl(0, 1'b1);
    tick(REL);
    check(rst, 1'b1);
    tick(8);
    check(rst, 1'b0);
    st(`VMC_ST_LVL0, 1'b0);
  endtask
  task automatic t_flags();
    bus(1'b1, 8'h04, EN);
    st(`VMC_ST_LVL1, 1'b1);
    lvl(2, 1'b0);
    st(`VMC_ST_LVL2, 1'b1);
    lvl(2, 1'b1);
    lvl(1, 1'b0);
    st(`VMC_ST_LVL1, 1'b0);
    tick(20);
    st(`VMC_ST_CROSS1, 1'b1);
    bus(1'b1, 8'h0C, 32'h4);
    st(`VMC_ST_CROSS1, 1'b0);
    lvl(1, 1'b1);
    st(`VMC_ST_CROSS1, 1'b1);
    bus(1'b1, 8'h0C, 32'h4);
    bus(1'b0, 8'h00, 32'h0);
    check(q === 32'h0, 1'b1);
  endtask
  task automatic t_cond();
    int n, e, nb;
    int tot[4] = '{1, 1, 2, 0};
    for (int c = 0; c < 4; c++) begin
      n = cmp.nmi_cnt;
      e = cmp.ev_cnt;
      bus(1'b1, 8'h04, EN | IQ | (c << 5));
      lvl(1, 1'b0);
      check(cmp.nmi_cnt - n == (c == 1 || c == 2), 1'b1);
      lvl(1, 1'b1);
      check(cmp.nmi_cnt - n == tot[c], 1'b1);
      check(cmp.ev_cnt - e == 2, 1'b1);
    end
    n = cmp.nmi_cnt;
    e = cmp.irq_cnt;
    nb = nmi_b_cnt;
    bus(1'b1, 8'h04, EN | IQ | TY | 32'h40);
    lvl(1, 1'b0);
    lvl(1, 1'b1);
    check(cmp.irq_cnt - e == 2 && cmp.nmi_cnt == n, 1'b1);
    check(nmi_b_cnt - nb == 2, 1'b1);
  endtask
  task automatic t_rst1();
    bus(1'b1, 8'h04, EN | RS);
    lvl(1, 1'b0);
    check(rst, 1'b1);
    cmp.set_lvl(1, 1'b1);
    tick(REL);
    check(rst, 1'b1);
    tick(8);
    check(rst, 1'b0);
    bus(1'b1, 8'h04, EN | RS | SL);
    cmp.set_lvl(1, 1'b0);
    tick(6);
    check(rst, 1'b1);
    tick(REL + 6);
    check(rst, 1'b0);
    lvl(1, 1'b1);
  endtask
  task automatic t_insel();
    int e;
    bus(1'b1, 8'h08, EN | 32'h400);
    e = cmp.ev2_cnt;
    lvl(2, 1'b0);
    st(`VMC_ST_LVL2, 1'b1);
    check(cmp.ev2_cnt == e, 1'b1);
    lvl(3, 1'b0);
    st(`VMC_ST_LVL2, 1'b0);
    st(`VMC_ST_CROSS2, 1'b1);
    check(cmp.ev2_cnt - e == 1, 1'b1);
  endtask
  // ch1 filter at n = 8: a change needs two agreeing samples, 56 to 130 cycles
  task automatic t_filt();
    bus(1'b1, 8'h04, EN | 32'h380);
    cmp.set_lvl(1, 1'b0);
    tick(36);
    bus(1'b0, 8'h0C, 32'h0);
    check(qb[`VMC_ST_LVL1], 1'b1);
    check(q[`VMC_ST_LVL1], 1'b0);
    tick(110);
    bus(1'b0, 8'h0C, 32'h0);
    check(qb[`VMC_ST_LVL1], 1'b0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    srst_in <= 1'b0;
    tick(REL + 10);
    t_ch0();
    t_flags();
    t_cond();
    t_rst1();
    t_insel();
    t_filt();
    wrap_up();
  end
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule
